// >>> rtl/lrnmf_mode_fsm.sv
`timescale 1ns/10ps

// Notes on behaviour
// RULE1: below power-on level stay reset, outputs high impedance, transceiver off, pull-up on.
// RULE2: supply above power-on level enters initialisation and sets error bit zero.
// RULE3: entering initialisation loads every internal register with its default.
// RULE4: initialisation reads address and config resistors; good read goes to normal.
// RULE5: failed resistor read sends the device to sleep instead of normal.
// RULE6: during initialisation transceiver off and all drivers high impedance.
// RULE7: initialisation always ends within its time limit, by either exit.
// RULE8: initialisation limit, counted from wake-up, is at most ten milliseconds.
// RULE9: normal or undervoltage goes to sleep after bus idle beyond the timeout.
// RULE10: bus idle timeout lies between four and ten seconds.
// RULE11: a go-to-sleep command received in normal mode enters sleep.
// RULE12: sleep turns outputs off, transceiver waits for wake, error bit kept.
// RULE13: wake needs dominant for the filter time then recessive; then initialisation.
// RULE14: master holds bus dominant at least the longest filter time, then releases.
// RULE15: transceiver on only in normal; off when unpowered, reset, init; wake in sleep.
// RULE16: a reset frame enters reset mode, restores defaults and sets error bit zero.
// RULE17: normal mode only after good initialisation; drivers follow bus commands there.
// RULE18: undervoltage disables transceiver, drivers unchanged; recovery returns to normal.
// RULE19: reset mode finishes and returns to normal with defaults, transceiver active.
// RULE20: idle counter restarts on each falling bus edge and runs in undervoltage.

module lrnmf_mode_fsm
    import lrnmf_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_LIMIT_CYCLES,
    parameter int IDLE_CYCLES = IDLE_TIMEOUT_CYCLES
) (
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    input  wire logic                   supplyAbovePor,
    input  wire logic                   supplyBelowUv,
    input  wire logic                   supplyAboveUvRecover,
    input  wire logic                   busLevel,
    input  wire logic                   configReadDone,
    input  wire logic                   configReadOk,
    input  wire logic                   goToSleepCmd,
    input  wire logic                   resetFrameCmd,
    input  wire logic                   driverCmdValid,
    input  wire logic [NUM_DRIVERS-1:0] driverCmdData,
    input  wire logic                   errorBit0Clear,
    output logic      [2:0]             modeState,
    output logic      [1:0]             transceiverMode,
    output logic                        busPullupWeak,
    output logic                        errorBit0,
    output logic      [NUM_DRIVERS-1:0] driverOutputs,
    output logic      [NUM_DRIVERS-1:0] driverEnable,
    output logic                        configReadStart,
    output logic                        registerDefaultLoad,
    output logic                        wakeDetected,
    output logic                        configFault
);

    // ***********************************************************
    // helpers
    // ***********************************************************
    function automatic lrnmf_xcvr_e xcvrFor(input lrnmf_mode_e m);
        lrnmf_xcvr_e x;
        x = XCVR_OFF;
        if (m == MODE_NORMAL) begin
            x = XCVR_ON;
        end else if (m == MODE_SLEEP) begin
            x = XCVR_WAKE;
        end
        return x;
    endfunction

    // ***********************************************************
    // pin synchronisers
    // ***********************************************************
    logic [3:0] pinsRaw;
    logic [3:0] pinsSync;
    logic       porOk;
    logic       uvLow;
    logic       uvRecover;
    logic       busSync;

    assign pinsRaw   = {busLevel, supplyAboveUvRecover, supplyBelowUv, supplyAbovePor};
    assign porOk     = pinsSync[0];
    assign uvLow     = pinsSync[1];
    assign uvRecover = pinsSync[2];
    assign busSync   = pinsSync[3];

    // bus idles recessive, supply flags idle as unpowered
    lrnmf_pin_sync #(
        .WIDTH       (4),
        .RESET_VALUE (8'h08)
    ) u_pinSync (
        .clock   (clock),
        .reset_n (reset_n),
        .pinIn   (pinsRaw),
        .pinOut  (pinsSync)
    );

    // ***********************************************************
    // state
    // ***********************************************************
    lrnmf_mode_e            mode;
    lrnmf_mode_e            next_mode;
    logic [COUNT_W-1:0]     initCount;
    logic [COUNT_W-1:0]     next_initCount;
    logic [COUNT_W-1:0]     idleCount;
    logic [COUNT_W-1:0]     next_idleCount;
    logic [WAKE_W-1:0]      wakeCount;
    logic [WAKE_W-1:0]      next_wakeCount;
    logic                   busPrev;
    logic                   next_busPrev;
    logic                   next_errorBit0;
    logic [NUM_DRIVERS-1:0] next_driverOutputs;
    logic [NUM_DRIVERS-1:0] next_driverEnable;
    logic                   next_configReadStart;
    logic                   next_registerDefaultLoad;
    logic                   next_wakeDetected;
    logic                   next_configFault;
    logic [1:0]             next_transceiverMode;
    logic                   next_busPullupWeak;

    logic                   busFall;
    logic                   idleExpired;
    logic                   initExpired;
    logic                   wakeQualified;
    logic                   errSet;

    assign busFall       = busPrev & ~busSync;
    assign idleExpired   = idleCount >= COUNT_W'(IDLE_CYCLES - 1);
    assign initExpired   = initCount >= COUNT_W'(INIT_CYCLES - 1);
    assign wakeQualified = wakeCount >= WAKE_W'(WAKE_FILTER_CYCLES);

    // ***********************************************************
    // mode sequencing
    // ***********************************************************
    always_comb begin
        next_mode = mode;
        errSet    = 1'b0;
        unique case (mode)
            MODE_UNPOWERED: begin
                if (porOk) begin
                    next_mode = MODE_INIT; // RULE2
                    errSet    = 1'b1; // RULE2
                end
            end
            MODE_INIT: begin
                if (configReadDone && configReadOk) begin
                    next_mode = MODE_NORMAL; // RULE4 RULE17
                end else if (configReadDone || initExpired) begin
                    // a read that never finishes counts as failed
                    next_mode = MODE_SLEEP; // RULE5 RULE7 RULE8
                end
            end
            MODE_NORMAL: begin
                if (uvLow) begin
                    next_mode = MODE_UNDERVOLT; // RULE18
                end else if (resetFrameCmd) begin
                    next_mode = MODE_RESET; // RULE16
                    errSet    = 1'b1; // RULE16
                end else if (goToSleepCmd) begin
                    next_mode = MODE_SLEEP; // RULE11
                end else if (idleExpired) begin
                    next_mode = MODE_SLEEP; // RULE9 RULE10
                end
            end
            MODE_UNDERVOLT: begin
                if (idleExpired) begin
                    next_mode = MODE_SLEEP; // RULE9
                end else if (uvRecover && !uvLow) begin
                    next_mode = MODE_NORMAL; // RULE18
                end
            end
            MODE_RESET: begin
                next_mode = MODE_NORMAL; // RULE19
            end
            MODE_SLEEP: begin
                if (wakeQualified && busSync == BUS_RECESSIVE) begin
                    next_mode = MODE_INIT; // RULE13
                end
            end
            default: begin
                next_mode = MODE_UNPOWERED;
            end
        endcase
        // supply loss overrides every mode
        if (!porOk) begin
            next_mode = MODE_UNPOWERED; // RULE1
            errSet    = 1'b0;
        end
    end

    // ***********************************************************
    // counters, outputs and flags
    // ***********************************************************
    always_comb begin
        next_busPrev             = busSync;
        next_initCount           = '0;
        next_idleCount           = '0;
        next_wakeCount           = '0;
        next_driverOutputs       = driverOutputs;
        next_driverEnable        = driverEnable;
        next_configReadStart     = 1'b0;
        next_registerDefaultLoad = 1'b0;
        next_wakeDetected        = 1'b0;
        next_configFault         = configFault;
        // set wins over a clear; sleep freezes the bit
        next_errorBit0 = errSet | (errorBit0 & ~(errorBit0Clear && mode != MODE_SLEEP)); // RULE12

        if (mode == MODE_INIT) begin
            next_initCount = initCount + COUNT_W'(1); // RULE7
        end

        if (mode == MODE_NORMAL || mode == MODE_UNDERVOLT) begin
            if (busFall) begin
                next_idleCount = '0; // RULE20
            end else if (!idleExpired) begin
                next_idleCount = idleCount + COUNT_W'(1); // RULE20
            end else begin
                next_idleCount = idleCount;
            end
        end

        if (mode == MODE_SLEEP && busSync == BUS_DOMINANT) begin
            // saturate so long dominant phases cannot wrap
            if (wakeQualified) begin
                next_wakeCount = wakeCount;
            end else begin
                next_wakeCount = wakeCount + WAKE_W'(1); // RULE13
            end
        end

        if (mode == MODE_NORMAL && next_mode == MODE_NORMAL && driverCmdValid) begin
            next_driverOutputs = driverCmdData; // RULE17
        end

        // entry actions keyed on the transition
        if (next_mode != mode) begin
            unique case (next_mode)
                MODE_UNPOWERED: begin
                    next_driverOutputs = DRIVER_ON_RESET; // RULE1
                    next_driverEnable  = DRIVER_EN_RESET; // RULE1
                end
                MODE_INIT: begin
                    next_driverOutputs       = DRIVER_ON_RESET; // RULE6
                    next_driverEnable        = DRIVER_EN_RESET; // RULE6
                    next_registerDefaultLoad = 1'b1; // RULE3
                    next_configReadStart     = 1'b1; // RULE4
                    next_wakeDetected        = (mode == MODE_SLEEP);
                end
                MODE_NORMAL: begin
                    next_driverEnable = DRIVER_EN_ALL; // RULE17
                    if (mode == MODE_INIT) begin
                        next_configFault = 1'b0;
                    end
                end
                MODE_SLEEP: begin
                    next_driverOutputs = DRIVER_ON_RESET; // RULE12
                    next_driverEnable  = DRIVER_EN_ALL; // RULE12
                    if (mode == MODE_INIT) begin
                        next_configFault = 1'b1; // RULE5
                    end
                end
                MODE_RESET: begin
                    next_driverOutputs       = DRIVER_ON_RESET; // RULE16
                    next_registerDefaultLoad = 1'b1; // RULE16
                end
                MODE_UNDERVOLT: begin
                    next_driverOutputs = driverOutputs; // RULE18
                end
                default: begin
                    next_driverEnable = DRIVER_EN_RESET;
                end
            endcase
        end

        next_transceiverMode = xcvrFor(next_mode); // RULE15
        // weak pull-up unless the transceiver is on
        next_busPullupWeak   = (xcvrFor(next_mode) != XCVR_ON); // RULE1
    end

    // ***********************************************************
    // registers
    // ***********************************************************
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mode                <= MODE_UNPOWERED;
            modeState           <= MODE_UNPOWERED;
            initCount           <= '0;
            idleCount           <= '0;
            wakeCount           <= '0;
            busPrev             <= BUS_RECESSIVE;
            errorBit0           <= ERR0_RESET;
            driverOutputs       <= DRIVER_ON_RESET;
            driverEnable        <= DRIVER_EN_RESET;
            configReadStart     <= 1'b0;
            registerDefaultLoad <= 1'b0;
            wakeDetected        <= 1'b0;
            configFault         <= 1'b0;
            transceiverMode     <= XCVR_OFF;
            busPullupWeak       <= 1'b1;
        end else begin
            mode                <= next_mode;
            modeState           <= next_mode;
            initCount           <= next_initCount;
            idleCount           <= next_idleCount;
            wakeCount           <= next_wakeCount;
            busPrev             <= next_busPrev;
            errorBit0           <= next_errorBit0;
            driverOutputs       <= next_driverOutputs;
            driverEnable        <= next_driverEnable;
            configReadStart     <= next_configReadStart;
            registerDefaultLoad <= next_registerDefaultLoad;
            wakeDetected        <= next_wakeDetected;
            configFault         <= next_configFault;
            transceiverMode     <= next_transceiverMode;
            busPullupWeak       <= next_busPullupWeak;
        end
    end

endmodule

// >>> rtl/lrnmf_pin_sync.sv
`timescale 1ns/10ps

module lrnmf_pin_sync
    import lrnmf_pkg::*;
#(
    parameter int         WIDTH       = 1,
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_pinOut;

    // ***********************************************************
    // agreement filter
    // ***********************************************************
    // stage1 feeds only stage2; a change counts once stage2 and stage3 agree
    always_comb begin
        next_pinOut = (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & pinOut);
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stage1 <= RESET_VALUE[WIDTH-1:0];
            stage2 <= RESET_VALUE[WIDTH-1:0];
            stage3 <= RESET_VALUE[WIDTH-1:0];
            pinOut <= RESET_VALUE[WIDTH-1:0];
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            pinOut <= next_pinOut;
        end
    end

endmodule

// >>> rtl/lrnmf_pkg.sv
package lrnmf_pkg;

    // ***********************************************************
    // clock and timing
    // ***********************************************************
    localparam int CLOCK_HZ            = 100_000_000;
    localparam int CLOCK_NS            = 10;

    // longest time: rounds down
    localparam int INIT_LIMIT_MS       = 10;
    localparam int INIT_LIMIT_CYCLES   = INIT_LIMIT_MS * (CLOCK_HZ / 1000);

    // least time: rounds up
    localparam int WAKE_FILTER_US      = 30;
    localparam int WAKE_FILTER_CYCLES  = (WAKE_FILTER_US * 1000 + CLOCK_NS - 1) / CLOCK_NS;

    // lower end of the permitted idle window
    localparam int IDLE_TIMEOUT_S      = 4;
    localparam int IDLE_TIMEOUT_CYCLES = IDLE_TIMEOUT_S * CLOCK_HZ;

    // ***********************************************************
    // widths
    // ***********************************************************
    localparam int COUNT_W             = 32;
    localparam int WAKE_W              = 16;
    localparam int NUM_DRIVERS         = 8;
    localparam int SYNC_STAGES         = 3;

    // ***********************************************************
    // reset values and bus levels
    // ***********************************************************
    localparam logic       BUS_RECESSIVE   = 1'b1;
    localparam logic       BUS_DOMINANT    = 1'b0;
    localparam logic       ERR0_RESET      = 1'b0;
    localparam logic [7:0] DRIVER_ON_RESET = 8'h00;
    localparam logic [7:0] DRIVER_EN_RESET = 8'h00;
    localparam logic [7:0] DRIVER_EN_ALL   = 8'hFF;

    // ***********************************************************
    // types
    // ***********************************************************
    typedef enum logic [2:0] {
        MODE_UNPOWERED = 3'b000,
        MODE_INIT      = 3'b001,
        MODE_NORMAL    = 3'b010,
        MODE_SLEEP     = 3'b011,
        MODE_RESET     = 3'b100,
        MODE_UNDERVOLT = 3'b101
    } lrnmf_mode_e;

    typedef enum logic [1:0] {
        XCVR_OFF  = 2'b00,
        XCVR_ON   = 2'b01,
        XCVR_WAKE = 2'b10
    } lrnmf_xcvr_e;

endpackage

// >>> tb/lrnmf_lin_master.sv
`timescale 1ns/10ps

module lrnmf_lin_master (
    input  wire logic clock,
    output logic      busLevel,
    output logic      goToSleepCmd,
    output logic      resetFrameCmd,
    output logic      driverCmdValid,
    output logic [7:0] driverCmdData
);
    localparam int WAKE_MAX_CYCLES = 15000;
    initial begin
        busLevel       = 1'b1;
        goToSleepCmd   = 1'b0;
        resetFrameCmd  = 1'b0;
        driverCmdValid = 1'b0;
        driverCmdData  = 8'h00;
    end
    // dominant for n edges, then released
    task automatic hold_dominant(input int n);
        busLevel = 1'b0;
        repeat (n) @(posedge clock);
        #1 busLevel = 1'b1;
    endtask
    task automatic wake();
        hold_dominant(WAKE_MAX_CYCLES);
    endtask
    // kind 0 sleep, 1 reset frame, 2 driver command
    task automatic send(input int kind, input logic [7:0] data);
        goToSleepCmd   = (kind == 0);
        resetFrameCmd  = (kind == 1);
        driverCmdValid = (kind == 2);
        driverCmdData  = data;
        @(posedge clock);
        #1;
        goToSleepCmd   = 1'b0;
        resetFrameCmd  = 1'b0;
        driverCmdValid = 1'b0;
        driverCmdData  = ~data;
    endtask
endmodule

// >>> tb/lrnmf_props.sv
`timescale 1ns/10ps

module lrnmf_props
    import lrnmf_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_LIMIT_CYCLES
) (
    input wire logic                   clock,
    input wire logic                   reset_n,
    input wire logic                   busLevel,
    input wire logic                   configReadDone,
    input wire logic                   configReadOk,
    input wire logic                   goToSleepCmd,
    input wire logic                   resetFrameCmd,
    input wire logic [2:0]             modeState,
    input wire logic [1:0]             transceiverMode,
    input wire logic                   busPullupWeak,
    input wire logic                   errorBit0,
    input wire logic [NUM_DRIVERS-1:0] driverOutputs,
    input wire logic [NUM_DRIVERS-1:0] driverEnable,
    input wire logic                   configReadStart,
    input wire logic                   registerDefaultLoad,
    input wire logic                   wakeDetected,
    input wire logic                   configFault
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!reset_n);

    // cycles in init; last finished dominant run
    int initCount;
    int domRun;
    int lastRun;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            initCount <= 0;
            domRun    <= 0;
            lastRun   <= 0;
        end else begin
            initCount <= (modeState == MODE_INIT) ? initCount + 1 : 0;
            domRun    <= (busLevel == BUS_DOMINANT) ? domRun + 1 : 0;
            if (busLevel == BUS_RECESSIVE && domRun != 0) lastRun <= domRun;
        end
    end

    // ***********************************************************
    // properties
    // ***********************************************************
    xcvr_map_a: assert property (transceiverMode == ((modeState == MODE_NORMAL) ? XCVR_ON :
        (modeState == MODE_SLEEP) ? XCVR_WAKE : XCVR_OFF)) else $error("transceiver mode wrong");
    hiz_modes_a: assert property (modeState inside {MODE_UNPOWERED, MODE_INIT} |->
        driverEnable == '0 && busPullupWeak) else $error("drivers enabled");
    por_entry_a: assert property ((modeState == MODE_INIT && $past(modeState) == MODE_UNPOWERED)
        |-> errorBit0 && registerDefaultLoad && configReadStart) else $error("bad init entry");
    init_limit_a: assert property (modeState == MODE_INIT |-> initCount <= INIT_CYCLES)
        else $error("init too long");
    init_ok_a: assert property ((modeState == MODE_INIT && configReadDone && configReadOk)
        |=> modeState inside {MODE_NORMAL, MODE_UNPOWERED}) else $error("good read not normal");
    init_fail_a: assert property ((modeState == MODE_INIT && configReadDone && !configReadOk)
        |=> (modeState == MODE_SLEEP && configFault) || modeState == MODE_UNPOWERED)
        else $error("failed read not sleep");
    normal_entry_a: assert property ((modeState == MODE_NORMAL && $past(modeState) != MODE_NORMAL)
        |-> $past(modeState) inside {MODE_INIT, MODE_RESET, MODE_UNDERVOLT})
        else $error("bad normal entry");
    sleep_cmd_a: assert property ((modeState == MODE_NORMAL && goToSleepCmd && !resetFrameCmd)
        |=> modeState != MODE_NORMAL) else $error("sleep command ignored");
    reset_cmd_a: assert property ((modeState == MODE_NORMAL && resetFrameCmd) ##1
        modeState == MODE_RESET |-> errorBit0 && registerDefaultLoad && driverOutputs == '0
        ##1 modeState == MODE_NORMAL) else $error("bad reset frame");
    sleep_hold_a: assert property ((modeState == MODE_SLEEP && $past(modeState) == MODE_SLEEP)
        |-> driverOutputs == '0 && $stable(errorBit0)) else $error("sleep state changed");
    wake_filter_a: assert property (wakeDetected |-> modeState == MODE_INIT &&
        $past(modeState) == MODE_SLEEP && lastRun >= WAKE_FILTER_CYCLES) else $error("bad wake");
    uv_hold_a: assert property ((modeState == MODE_UNDERVOLT && $past(modeState) != MODE_UNPOWERED)
        |-> driverOutputs == $past(driverOutputs)) else $error("drivers moved");

    cover property (wakeDetected);
    cover property (modeState == MODE_RESET);
    cover property (modeState == MODE_UNDERVOLT);
    cover property (configFault && modeState == MODE_SLEEP);
endmodule

bind lrnmf_mode_fsm lrnmf_props #(.INIT_CYCLES(INIT_CYCLES)) u_props (
    .clock, .reset_n, .busLevel, .configReadDone, .configReadOk, .goToSleepCmd,
    .resetFrameCmd, .modeState, .transceiverMode, .busPullupWeak, .errorBit0,
    .driverOutputs, .driverEnable, .configReadStart, .registerDefaultLoad, .wakeDetected,
    .configFault);

// >>> tb/tb_lin_relay_node_mode_fsm.sv
`timescale 1ns/10ps

module tb_lin_relay_node_mode_fsm
    import lrnmf_pkg::*;
;
    localparam int INIT_N = 50;
    localparam int IDLE_N = 200;
    logic clock = 1'b0;
    logic reset_n, supplyAbovePor, supplyBelowUv, supplyAboveUvRecover;
    logic configReadDone, configReadOk, errorBit0Clear;
    logic busLevel, goToSleepCmd, resetFrameCmd, driverCmdValid;
    logic [7:0] driverCmdData, driverOutputs, driverEnable, expDrv;
    logic [2:0] modeState;
    logic [1:0] transceiverMode;
    logic busPullupWeak, errorBit0, configReadStart, registerDefaultLoad, wakeDetected;
    logic configFault;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 64;
    int k;

    always #5 clock = ~clock;

    lrnmf_mode_fsm #(.INIT_CYCLES(INIT_N), .IDLE_CYCLES(IDLE_N)) u_lrnmf_mode_fsm (
        .clock, .reset_n, .supplyAbovePor, .supplyBelowUv, .supplyAboveUvRecover, .busLevel,
        .configReadDone, .configReadOk, .goToSleepCmd, .resetFrameCmd, .driverCmdValid,
        .driverCmdData, .errorBit0Clear, .modeState, .transceiverMode, .busPullupWeak,
        .errorBit0, .driverOutputs, .driverEnable, .configReadStart, .registerDefaultLoad,
        .wakeDetected, .configFault);
    lrnmf_lin_master u_master (.clock, .busLevel, .goToSleepCmd, .resetFrameCmd,
        .driverCmdValid, .driverCmdData);

    // ***********************************************************
    // model and checks
    // ***********************************************************
    function automatic logic [1:0] xcvr_of(input int m);
        return (m == MODE_NORMAL) ? XCVR_ON : (m == MODE_SLEEP) ? XCVR_WAKE : XCVR_OFF;
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_mode(input int m);
        chk_bits({5'h00, modeState}, m[7:0]);
        chk_bits({6'h00, transceiverMode}, {6'h00, xcvr_of(m)});
        chk_bits({7'h00, busPullupWeak}, {7'h00, xcvr_of(m) != XCVR_ON});
        chk_bits(driverOutputs, expDrv);
    endtask
    // bounded wait for a mode, then compare
    task automatic wait_mode(input int m, input int lim);
        int i;
        for (i = 0; i < lim && modeState !== m[2:0]; i++) step(1);
        chk_mode(m);
    endtask
    task automatic read_config(input logic ok);
        configReadDone = 1'b1;
        configReadOk   = ok;
        step(1);
        configReadDone = 1'b0;
        configReadOk   = ~ok;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #800_000;
        num_errors++;
        stop_test();
    end

    // ***********************************************************
    // main sequence
    // ***********************************************************
    initial begin
        reset_n = 1'b0;
        supplyAbovePor = 1'b0;
        supplyBelowUv = 1'b0;
        supplyAboveUvRecover = 1'b1;
        configReadDone = 1'b0;
        configReadOk = 1'b0;
        errorBit0Clear = 1'b0;
        expDrv = 8'h00;
        step(10);
        wait_mode(MODE_UNPOWERED, 0);
        chk_bits(driverEnable, 8'h00);
        reset_n = 1'b1;
        step(3);
        supplyAbovePor = 1'b1;
        wait_mode(MODE_INIT, 10);
        chk_bits({5'h00, errorBit0, registerDefaultLoad, configReadStart}, 8'h07);
        chk_bits(driverEnable, 8'h00);
        step(2);
        read_config(1'b1);
        wait_mode(MODE_NORMAL, 0);
        chk_bits(driverEnable, 8'hFF);
        expDrv = 8'($random(seed));
        u_master.send(2, expDrv);
        chk_mode(MODE_NORMAL);
        errorBit0Clear = 1'b1;
        step(1);
        errorBit0Clear = 1'b0;
        chk_bits({7'h00, errorBit0}, 8'h00);
        u_master.send(1, 8'h00);
        expDrv = 8'h00;
        chk_mode(MODE_RESET);
        chk_bits({6'h00, errorBit0, registerDefaultLoad}, 8'h03);
        step(1);
        chk_mode(MODE_NORMAL);
        expDrv = 8'($random(seed));
        u_master.send(2, expDrv);
        supplyBelowUv = 1'b1;
        supplyAboveUvRecover = 1'b0;
        wait_mode(MODE_UNDERVOLT, 8);
        u_master.send(0, 8'h00);
        chk_mode(MODE_UNDERVOLT);
        supplyBelowUv = 1'b0;
        supplyAboveUvRecover = 1'b1;
        wait_mode(MODE_NORMAL, 8);
        repeat (4) begin
            step(130);
            u_master.hold_dominant(20);
        end
        chk_mode(MODE_NORMAL);
        step(IDLE_N - 30);
        chk_mode(MODE_NORMAL);
        expDrv = 8'h00;
        wait_mode(MODE_SLEEP, 30);
        errorBit0Clear = 1'b1;
        u_master.hold_dominant(WAKE_FILTER_CYCLES - 10);
        errorBit0Clear = 1'b0;
        step(20);
        chk_mode(MODE_SLEEP);
        chk_bits({7'h00, errorBit0}, 8'h01);
        // outcomes: init timeout, failed read, good read
        for (k = 0; k < 3; k++) begin
            u_master.wake();
            wait_mode(MODE_INIT, 8);
            chk_bits({6'h00, wakeDetected, driverEnable[0]}, 8'h02);
            if (k > 0) read_config(k == 2);
            wait_mode(k == 2 ? MODE_NORMAL : MODE_SLEEP, k == 0 ? INIT_N + 1 : 0);
            chk_bits({7'h00, configFault}, {7'h00, k != 2});
        end
        expDrv = 8'($random(seed));
        u_master.send(2, expDrv);
        chk_bits(driverOutputs, expDrv);
        step(1);
        u_master.send(0, 8'h00);
        expDrv = 8'h00;
        chk_mode(MODE_SLEEP);
        supplyAbovePor = 1'b0;
        wait_mode(MODE_UNPOWERED, 8);
        chk_bits(driverEnable, 8'h00);
        stop_test();
    end
endmodule
